// ---- rtl/cdg_diag.sv ----
// Coupler diagnosis block builder and integrated slave output configuration.
// Scan reports and supply readings come from logic on the same clock;
// configuration switches are raw pins and are synchronised here.
module cdg_diag
	import cdg_pkg::*;
#(
	parameter int HB_COUNT = HB_CYCLES
) (
	// Clock and reset
	input wire logic clock,
	input wire logic srst,
	// Supply readings, 10 mV units
	input wire logic [15:0] elec_ext_cv,
	input wire logic [15:0] valve_ext_cv,
	input wire logic [15:0] elec_own_cv,
	// Link scan report
	input wire cdg_scan_t scan,
	// Configuration switch pins
	input wire logic [1:0] link_rate_switch,
	input wire logic [1:0] output_length_switch,
	input wire logic [3:0] participant_address_switch,
	// Slave output data from the control
	input wire logic [31:0] slave_out_data,
	// Diagnosis block towards the host
	output logic [7:0] fault_flags,
	output logic [7:0] input_length_heartbeat,
	output logic [7:0] presence_low,
	output logic [7:0] presence_high,
	// Slave configuration and valve drive
	output logic [3:0] slave_address,
	output logic link_rate_fast,
	output logic [2:0] slave_out_len,
	output logic [23:0] downstream_link_connector,
	output logic cfg_ready
);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic out_of(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
		return (v < lo) || (v > hi);
	endfunction

	// Set addresses must form one unbroken run starting at address 1
	function automatic logic has_gap(input logic [13:0] p);
		logic [14:0] q;
		q = {1'b0, p} + 15'h0001;
		return |p && ((q & {1'b0, p}) != 15'h0000);
	endfunction

	function automatic logic [7:0] count_of(input logic [14:0] p);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i <= MAX_ADDR; i++) begin
			c = c + {7'h00, p[i]};
		end
		return c;
	endfunction

	// ----------------------------------------
	// Switch synchroniser and power-up capture
	// ----------------------------------------
	typedef enum logic [1:0] {ST_SETTLE, ST_RUN} cdg_state_t;

	cdg_sw_t sw_meta, sw_sync, sw_held, next_sw_held;
	cdg_state_t state, next_state;
	logic [1:0] settle, next_settle;
	logic [2:0] next_slave_out_len;
	logic next_cfg_ready;

	always_ff @(posedge clock) begin
		sw_meta <= {link_rate_switch, output_length_switch, participant_address_switch};
		sw_sync <= sw_meta;
	end

	always_comb begin
		next_state = state;
		next_settle = settle;
		next_sw_held = sw_held;
		next_cfg_ready = cfg_ready;
		case (state)
			ST_SETTLE: begin
				// Wait until the synchroniser holds real pin levels
				if (settle == SW_SETTLE) begin
					next_sw_held = sw_sync;
					next_cfg_ready = 1'b1;
					next_state = ST_RUN;
				end else begin
					next_settle = settle + 2'h1;
				end
			end
			ST_RUN: begin
				next_state = ST_RUN;
			end
			default: begin
				next_state = ST_SETTLE;
			end
		endcase
		unique case ({next_sw_held.output_length_switch[LEN_BIT_B], next_sw_held.output_length_switch[LEN_BIT_A]})
			2'b00: next_slave_out_len = 3'h1;
			2'b01: next_slave_out_len = 3'h2;
			2'b10: next_slave_out_len = 3'h3;
			default: next_slave_out_len = 3'h4;
		endcase
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state <= ST_SETTLE;
			settle <= 2'h0;
			sw_held <= '0;
			cfg_ready <= 1'b0;
			slave_address <= 4'h0;
			link_rate_fast <= 1'b0;
			slave_out_len <= 3'h1;
		end else begin
			state <= next_state;
			settle <= next_settle;
			sw_held <= next_sw_held;
			cfg_ready <= next_cfg_ready;
			slave_address <= next_sw_held.participant_address_switch;
			// One rate setting serves master and slave alike
			link_rate_fast <= next_sw_held.link_rate_switch[RATE_BIT];
			slave_out_len <= next_slave_out_len;
		end
	end

	// ----------------------------------------
	// Valve drive
	// ----------------------------------------
	logic [23:0] next_valve;

	always_comb begin
		next_valve = 24'h000000;
		// Byte 4 only pads to 16-bit words and never reaches a pin
		for (int b = 0; b < 3; b++) begin
			if (cfg_ready && (3'(b) < slave_out_len)) begin
				next_valve[b*8 +: 8] = slave_out_data[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			downstream_link_connector <= 24'h000000;
		end else begin
			downstream_link_connector <= next_valve;
		end
	end

	// ----------------------------------------
	// Diagnosis bytes
	// ----------------------------------------
	logic [7:0] last_count, next_last_count;
	logic [7:0] last_lsum, next_last_lsum;
	logic have_last, next_have_last;
	logic [31:0] hb_cnt, next_hb_cnt;
	logic [7:0] next_fault, next_len_hb, next_pres_lo, next_pres_hi;

	always_comb begin
		next_last_count = last_count;
		next_last_lsum = last_lsum;
		next_have_last = have_last;
		next_fault = fault_flags;
		next_len_hb = input_length_heartbeat;
		next_pres_lo = presence_low;
		next_pres_hi = presence_high;
		next_hb_cnt = hb_cnt + 32'h1;
		if (hb_cnt >= 32'(HB_COUNT - 1)) begin
			next_hb_cnt = 32'h0;
			next_len_hb[BIT_HEARTBEAT] = ~input_length_heartbeat[BIT_HEARTBEAT];
		end
		next_fault[BIT_ELEC_EXT] = out_of(elec_ext_cv, ELEC_MIN_CV, ELEC_MAX_CV);
		next_fault[BIT_VALVE_EXT] = out_of(valve_ext_cv, VALVE_MIN_CV, VALVE_MAX_CV);
		next_fault[BIT_ELEC_OWN] = out_of(elec_own_cv, ELEC_MIN_CV, ELEC_MAX_CV);
		if (scan.valid) begin
			next_fault[BIT_NO_PART] = (scan.present == 15'h0000);
			next_fault[BIT_ADDR_ERR] = scan.duplicate || has_gap(scan.present[14:1])
				|| (scan.present[0] && |scan.present[14:1]);
			// A change is judged only against an earlier scan; power-up leaves it set
			if (have_last) begin
				next_fault[BIT_CFG_CHG] = (count_of(scan.present) != last_count)
					|| (scan.length_sum != last_lsum);
			end
			next_last_count = count_of(scan.present);
			next_last_lsum = scan.length_sum;
			next_have_last = 1'b1;
			next_len_hb[6:0] = scan.diag_len + MASTER_DIAG_BYTES;
			if (scan.auto_mode) begin
				next_pres_lo = {3'h0, scan.types};
				next_pres_hi = 8'h00;
			end else begin
				next_pres_lo = scan.present[8:1];
				next_pres_hi = {2'h0, scan.present[14:9]};
			end
		end
		next_fault[7:6] = 2'h0;
		next_pres_hi[7:6] = 2'h0;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			fault_flags <= FAULT_FLAGS_RST;
			input_length_heartbeat <= {1'b0, MASTER_DIAG_BYTES};
			presence_low <= 8'h00;
			presence_high <= 8'h00;
			last_count <= 8'h00;
			last_lsum <= 8'h00;
			have_last <= 1'b0;
			hb_cnt <= 32'h0;
		end else begin
			fault_flags <= next_fault;
			input_length_heartbeat <= next_len_hb;
			presence_low <= next_pres_lo;
			presence_high <= next_pres_hi;
			last_count <= next_last_count;
			last_lsum <= next_last_lsum;
			have_last <= next_have_last;
			hb_cnt <= next_hb_cnt;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	AST_ELEC_EXT: assert property (
		(elec_ext_cv < ELEC_MIN_CV || elec_ext_cv > ELEC_MAX_CV) |=> fault_flags[BIT_ELEC_EXT])
		else $error("external electronics fault not flagged");
	AST_VALVE_EXT: assert property (
		(valve_ext_cv >= VALVE_MIN_CV && valve_ext_cv <= VALVE_MAX_CV) |=> !fault_flags[BIT_VALVE_EXT])
		else $error("valve supply flagged while in window");
	AST_ELEC_OWN: assert property (
		!$past(srst) |-> fault_flags[BIT_ELEC_OWN] == $past(elec_own_cv < ELEC_MIN_CV || elec_own_cv > ELEC_MAX_CV))
		else $error("own supply flag mismatch");
	AST_NO_PART: assert property (
		(scan.valid && scan.present == 15'h0000) |=> fault_flags[BIT_NO_PART] && presence_low == 8'h00)
		else $error("empty link not flagged");
	AST_ADDR_ERR: assert property (
		(scan.valid && scan.present[0] && scan.present[1]) |=> fault_flags[BIT_ADDR_ERR])
		else $error("mixed addressing not flagged");
	AST_ADDR_DUP: assert property (
		(scan.valid && scan.duplicate) |=> fault_flags[BIT_ADDR_ERR])
		else $error("duplicate address not flagged");
	AST_CFG_FIRST: assert property (
		(scan.valid && !have_last) |=> fault_flags[BIT_CFG_CHG])
		else $error("first scan after power-up cleared the configuration flag");
	AST_CFG_SAME: assert property (
		(scan.valid && have_last && count_of(scan.present) == last_count && scan.length_sum == last_lsum)
			|=> !fault_flags[BIT_CFG_CHG])
		else $error("configuration flag set on a matching scan");
	AST_CFG_PWR: assert property (
		$fell(srst) |-> fault_flags[BIT_CFG_CHG])
		else $error("configuration flag not set after power-up");
	AST_LENGTH: assert property (
		scan.valid |=> input_length_heartbeat[6:0] == $past(scan.diag_len) + MASTER_DIAG_BYTES)
		else $error("input length wrong");
	AST_HB_STEADY: assert property (
		(hb_cnt != 32'(HB_COUNT - 1)) |=> $stable(input_length_heartbeat[BIT_HEARTBEAT]))
		else $error("heartbeat toggled early");
	AST_PRESENCE: assert property (
		(scan.valid && !scan.auto_mode) |=> presence_high[5:0] == $past(scan.present[14:9]))
		else $error("presence bits wrong");
	AST_AUTO_TYPES: assert property (
		(scan.valid && scan.auto_mode) |=> presence_low == {3'h0, $past(scan.types)})
		else $error("type bits wrong");
	AST_FROZEN: assert property (
		(state == ST_RUN) |=> $stable(slave_address) && $stable(link_rate_fast) && $stable(slave_out_len))
		else $error("switch setting changed during operation");
	AST_LEN_SEL: assert property (
		cfg_ready |-> slave_out_len == 3'h1 + {1'b0, sw_held.output_length_switch[LEN_BIT_B],
			sw_held.output_length_switch[LEN_BIT_A]})
		else $error("output length does not follow switch");
	AST_THREE_BYTES: assert property (
		(cfg_ready && slave_out_len == 3'h4) |=> downstream_link_connector == $past(slave_out_data[23:0]))
		else $error("valve bytes not driven");
	AST_ZERO_BITS: assert property (
		fault_flags[7:6] == 2'h0 && presence_high[7:6] == 2'h0)
		else $error("unassigned bits not zero");

	COV_HEARTBEAT: cover property ($changed(input_length_heartbeat[BIT_HEARTBEAT]));
	COV_CFG_CHANGE: cover property (fault_flags[BIT_CFG_CHG] ##1 !fault_flags[BIT_CFG_CHG]);
	COV_AUTO: cover property (scan.valid && scan.auto_mode);
	COV_FOUR_BYTES: cover property (cfg_ready && slave_out_len == 3'h4);

endmodule // cdg_diag

// ---- rtl/cdg_pkg.sv ----
// Shared constants and carrier types for the coupler diagnosis block.
// Assumes one 125 MHz system clock and a synchronous active-high reset.
package cdg_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam int CLK_KHZ = 125000;
	localparam int HB_PERIOD_MS = 2500;
	// Half-period of the liveness bit, inside the 2..3 s window
	localparam int HB_CYCLES = CLK_KHZ * HB_PERIOD_MS;
	localparam logic [1:0] SW_SETTLE = 2'h3;

	// ----------------------------------------
	// Supply windows, in units of 10 mV
	// ----------------------------------------
	localparam logic [15:0] ELEC_MIN_CV = 16'h0780;
	localparam logic [15:0] ELEC_MAX_CV = 16'h0b40;
	localparam logic [15:0] VALVE_MIN_CV = 16'h0870;
	localparam logic [15:0] VALVE_MAX_CV = 16'h0a50;

	// ----------------------------------------
	// Diagnosis block layout
	// ----------------------------------------
	localparam int FAULT_FLAGS_OFS = 0;
	localparam int INPUT_LENGTH_HEARTBEAT_OFS = 1;
	localparam int PRESENCE_LOW_OFS = 2;
	localparam int PRESENCE_HIGH_OFS = 3;
	localparam int BIT_ELEC_EXT = 0;
	localparam int BIT_VALVE_EXT = 1;
	localparam int BIT_ELEC_OWN = 2;
	localparam int BIT_NO_PART = 3;
	localparam int BIT_ADDR_ERR = 4;
	localparam int BIT_CFG_CHG = 5;
	localparam int BIT_HEARTBEAT = 7;
	localparam logic [6:0] MASTER_DIAG_BYTES = 7'h04;
	localparam logic [7:0] FAULT_FLAGS_RST = 8'h20;
	localparam int MAX_ADDR = 14;

	// ----------------------------------------
	// Switch fields
	// ----------------------------------------
	localparam int RATE_BIT = 0;
	localparam int LEN_BIT_A = 0;
	localparam int LEN_BIT_B = 1;

	// Configuration switch levels as sampled at power-up
	typedef struct packed {
		logic [1:0] link_rate_switch;
		logic [1:0] output_length_switch;
		logic [3:0] participant_address_switch;
	} cdg_sw_t;

	// One finished link scan from the link engine
	typedef struct packed {
		logic valid;
		logic [14:0] present;
		logic duplicate;
		logic auto_mode;
		logic [4:0] types;
		logic [7:0] length_sum;
		logic [6:0] diag_len;
	} cdg_scan_t;

endpackage

// ---- tb/cdg_link_model.sv ----
// Far-side link model: turns a participant setup into one scan report.
// Assumes the bench pulses go for one cycle; the report follows one edge later.
module cdg_link_model
	import cdg_pkg::*;
(
	// Clock
	input wire logic clock,
	// Participant setup
	input wire logic go,
	input wire logic [3:0] cnt,
	input wire logic dup,
	input wire logic gap,
	input wire logic mix,
	input wire logic auto_on,
	input wire logic [4:0] types,
	// Scan report
	output cdg_scan_t scan
);
	timeunit 1ns;
	timeprecision 1ps;

	cdg_scan_t next_scan;

	always_comb begin
		next_scan = '0;
		next_scan.valid = go;
		// Addresses run from 1 without holes unless a fault is commanded
		next_scan.present = 15'((32'h1 << (cnt + 1)) - 2);
		next_scan.present[2] = next_scan.present[2] & ~gap;
		next_scan.present[0] = mix;
		next_scan.duplicate = dup;
		if (auto_on) begin
			next_scan.present = 15'h0001;
			next_scan.auto_mode = 1'b1;
			next_scan.types = types;
		end
		next_scan.length_sum = 8'(cnt * 2);
		next_scan.diag_len = 7'(cnt * 3);
	end

	always_ff @(posedge clock) begin
		scan <= next_scan;
	end
endmodule // cdg_link_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the coupler diagnosis block.
// Assumes the link model on the scan port; supplies and switches come from here.
module tb_top
	import cdg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	localparam int HB_SIM = 20;
	logic clock = 1'b0, srst = 1'b1, go = 1'b0, dup = 1'b0, gap = 1'b0, mix = 1'b0, auto_on = 1'b0;
	logic [15:0] elec_ext_cv = 16'h0960, valve_ext_cv = 16'h0960, elec_own_cv = 16'h0960;
	logic [1:0] link_rate_switch = 2'h0, output_length_switch = 2'h0;
	logic [3:0] participant_address_switch = 4'h0, cnt = 4'h0, slave_address;
	logic [31:0] slave_out_data = 32'h0, seed = 32'h121f3c5a;
	logic [4:0] types = 5'h00;
	logic [7:0] fault_flags, input_length_heartbeat, presence_low, presence_high;
	logic [2:0] slave_out_len;
	logic [23:0] downstream_link_connector;
	logic link_rate_fast, cfg_ready;
	cdg_scan_t scan;
	int err_total = 0, compares = 0, first = 1, pcnt = 0, plen = 0;

	cdg_link_model link (.clock(clock), .go(go), .cnt(cnt), .dup(dup), .gap(gap), .mix(mix),
		.auto_on(auto_on), .types(types), .scan(scan));
	cdg_diag #(.HB_COUNT(HB_SIM)) uut (.clock(clock), .srst(srst), .elec_ext_cv(elec_ext_cv),
		.valve_ext_cv(valve_ext_cv), .elec_own_cv(elec_own_cv), .scan(scan),
		.link_rate_switch(link_rate_switch), .output_length_switch(output_length_switch),
		.participant_address_switch(participant_address_switch), .slave_out_data(slave_out_data),
		.fault_flags(fault_flags), .input_length_heartbeat(input_length_heartbeat),
		.presence_low(presence_low), .presence_high(presence_high), .slave_address(slave_address),
		.link_rate_fast(link_rate_fast), .slave_out_len(slave_out_len),
		.downstream_link_connector(downstream_link_connector), .cfg_ready(cfg_ready));

	initial begin
		forever #4 clock = ~clock;
	end

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic test_done();
		$display("compares %0d err_total %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Power-up with fixed switch levels, then wait for the capture
	task automatic boot(input logic [1:0] lr, input logic [1:0] ol, input logic [3:0] ad);
		@(negedge clock);
		link_rate_switch = lr;
		output_length_switch = ol;
		participant_address_switch = ad;
		srst = 1'b1;
		repeat (3) @(negedge clock);
		chk("fault_flags", 32'h20, fault_flags);
		chk("byte1", 32'h04, input_length_heartbeat);
		srst = 1'b0;
		first = 1;
		for (int i = 0; i < 20 && cfg_ready !== 1'b1; i++) @(negedge clock);
		chk("cfg_ready", 32'h1, cfg_ready);
	endtask

	task automatic do_scan(input int c, input logic d, input logic g, input logic m, input logic a,
		input logic [4:0] ty, input logic full);
		logic [14:0] pm;
		int n;
		@(negedge clock);
		{cnt, dup, gap, mix, auto_on, types, go} = {4'(c), d, g, m, a, ty, 1'b1};
		@(negedge clock);
		go = 1'b0;
		@(negedge clock);
		pm = a ? 15'h0001 : 15'((32'h1 << (c + 1)) - 2) & ~15'(g ? 4 : 0) | 15'(m);
		n = $countones(pm);
		chk("presence_low", a ? 32'(ty) : 32'(pm[8:1]), presence_low);
		chk("presence_high", a ? 32'h0 : 32'(pm[14:9]), presence_high);
		chk("fault_spare", 32'h0, fault_flags[7:6]);
		chk("total_len", 32'((4 + 3 * c) & 32'h7f), input_length_heartbeat[6:0]);
		if (full) begin
			chk("no_part", 32'(c == 0), fault_flags[3]);
			chk("addr_err", 32'(d | g | (m && c > 0)), fault_flags[4]);
			chk("cfg_chg", first ? 32'h1 : 32'(n != pcnt || 2 * c != plen), fault_flags[5]);
		end
		// Every scan becomes the reference for the next one, checked or not
		first = 0;
		pcnt = n;
		plen = 2 * c;
	endtask

	initial begin
		#100000;
		err_total++;
		test_done();
	end

	initial begin
		logic [15:0] lo, hi, v;
		logic hb;
		int nb;
		for (int k = 0; k < 4; k++) begin
			boot(2'(k & 1), 2'(k), 4'(k * 3 + 1));
			chk("slave_address", 32'(k * 3 + 1), slave_address);
			chk("link_rate_fast", 32'(k & 1), link_rate_fast);
			chk("slave_out_len", 32'(k + 1), slave_out_len);
			seed = lfsr_next(seed);
			slave_out_data = seed;
			@(negedge clock);
			nb = (k + 1 > 3) ? 3 : k + 1;
			chk("connector", seed & ((32'h1 << (8 * nb)) - 1), downstream_link_connector);
			{link_rate_switch, output_length_switch, participant_address_switch} = ~8'(k * 3 + 1);
			repeat (8) @(negedge clock);
			chk("late_switch", 32'({4'(k * 3 + 1), 1'(k & 1), 3'(k + 1)}),
				{slave_address, link_rate_fast, slave_out_len});
		end
		for (int h = 0; h < 2; h++) begin
			hb = input_length_heartbeat[7];
			repeat (HB_SIM) @(negedge clock);
			chk("heartbeat", {31'h0, ~hb}, input_length_heartbeat[7]);
		end
		// Each rail at both window edges and one step outside them
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 4; k++) begin
				lo = (r == 1) ? VALVE_MIN_CV : ELEC_MIN_CV;
				hi = (r == 1) ? VALVE_MAX_CV : ELEC_MAX_CV;
				v = (k == 0) ? lo - 1 : (k == 1) ? lo : (k == 2) ? hi : hi + 1;
				elec_ext_cv = (r == 0) ? v : 16'h0960;
				valve_ext_cv = (r == 1) ? v : 16'h0960;
				elec_own_cv = (r == 2) ? v : 16'h0960;
				@(negedge clock);
				@(negedge clock);
				chk("supply_bit", 32'(k == 0 || k == 3), fault_flags[r]);
			end
		end
		elec_own_cv = 16'h0960;
		do_scan(0, 0, 0, 0, 0, 5'h00, 1);
		do_scan(3, 0, 0, 0, 0, 5'h00, 1);
		do_scan(3, 0, 0, 0, 0, 5'h00, 1);
		do_scan(14, 0, 0, 0, 0, 5'h00, 1);
		do_scan(14, 1, 0, 0, 0, 5'h00, 1);
		do_scan(5, 0, 1, 0, 0, 5'h00, 1);
		do_scan(4, 0, 0, 1, 0, 5'h00, 1);
		do_scan(0, 0, 0, 0, 1, 5'h15, 0);
		test_done();
	end
endmodule // tb_top
